// ==== include/vcr_consts.svh ====
/*
 * Constants of the valve current regulator: register offsets, field positions,
 * reset values and timing counts. Assumes a 10 MHz system clock.
 */
`ifndef VCR_CONSTS_SVH
`define VCR_CONSTS_SVH

// ==========================================================
// register map (byte addresses)
`define VCR_OFF_CTRL      8'h00
`define VCR_OFF_GAIN      8'h04
`define VCR_OFF_FCLR      8'h08
`define VCR_OFF_STATUS    8'h0C
`define VCR_OFF_SETPOINT  8'h10
// ==========================================================
// control fields
`define VCR_CTRL_MINDUTY_LSB  0
`define VCR_CTRL_PAIR12_BIT   2
`define VCR_CTRL_PAIR34_BIT   3
`define VCR_CTRL_RDSEL_BIT    4
`define VCR_CTRL_FIRST_DUTY_CONTROL_BIT     5
`define VCR_CTRL_RESET        6'h00
// gains: 6 fractional bits, integral gain resets to 1/8
`define VCR_GAIN_FRAC         6
`define VCR_KI_RESET          8'h08
`define VCR_KP_RESET          8'h00
// ==========================================================
// duty scale: 1024 is 100 %
`define VCR_DUTY_FULL     11'h400
`define VCR_DUTY_MIN10    11'h066
`define VCR_DUTY_MIN3     11'h020
`define VCR_DUTY_FORCED   11'h010
`define VCR_ERR_THRESH    12'h019
// sample point slope: (102 - duty) / 70 as (x * 117) >> 13
`define VCR_SLOPE_MUL     7'h75
`define VCR_SLOPE_SHIFT   13
// ==========================================================
// timing
`define VCR_CLK_HZ        10000000
`define VCR_PWM_HZ        5000
`define VCR_PERIOD_CYC    (`VCR_CLK_HZ / `VCR_PWM_HZ)
`define VCR_FILTER_NS     2000
`define VCR_FILTER_CYC    ((`VCR_FILTER_NS * (`VCR_CLK_HZ / 1000000) + 999) / 1000)
`define VCR_CRERR_US      1000
`define VCR_CRERR_CYC     (`VCR_CRERR_US * (`VCR_CLK_HZ / 1000000))

`endif

// ==== include/vcr_pkg.sv ====
/*
 * Types of the valve current regulator.
 * Assumes vcr_consts.svh is on the include path.
 */
`default_nettype none
package vcr_pkg;
	// ==========================================================
	// per-channel flags as they appear in the status word
	typedef struct packed {
		logic drain_state;
		logic overtemp;
		logic overcurrent;
		logic open_load;
		logic regulation_error_flag;
	} vcr_flags_t;

	// ==========================================================
	// write channel of the bus slave
	typedef enum logic [1:0] {
		VCR_WR_IDLE = 2'b01,
		VCR_WR_RESP = 2'b10
	} vcr_wstate_t;
endpackage
`default_nettype wire

// ==== logic/vcr_regulator.sv ====
/*
 * Four-channel valve current regulator with PWM, PI loop, sample scheduling and
 * fault supervision, behind an AXI4-Lite register slave.
 * Assumes the ADC, comparators and power stages are outside and synchronous to aclk.
 */
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
// Notes on behaviour
// - each channel owns a 10-bit setpoint, 2.2 mA per step
// - zero setpoint turns the channel's power stage off
// - a new setpoint acts on the loop at once
// - setpoint readback chosen by pair mode bit and readback select
// - duty follows a PI law with programmable integral and proportional gains
// - one integral gain for all channels, reset value one eighth
// - regulators idle until integral gain is non-zero
// - two-bit option picks minimum duty and forced or skipped pulses
// - regulated duty clamped between minimum and 100 percent
// - sample at half on-time, moving to end below 10 percent
// - current sampled only while the switch is on
// - error flag after setpoint minus current exceeds 25 for the delay
// - regulation error only reported, loop keeps running
// - error flag latched, cleared by reading it
// - pair regulation off bit makes channels plain PWM from top 8 bits
// - first period duty set by the first duty control bit
// - open load checked only while off, flag only
// - filtered drain state bit per channel, readable
// - overcurrent switches off and latches; clear then new setpoint
// - overtemperature switches off, drops turn-on; clear then new setpoint
// - PWM code 0.39 percent per step, 00 off, FF on
// - channel periods interleaved by quarter period from channel one
`default_nettype none
`include "vcr_consts.svh"

// ==========================================================
// debouncer: level follows raw after it has differed for N cycles
module vcr_debounce #(
	parameter int N = 20
) (
	input  wire logic aclk,    // system clock
	input  wire logic aresetn, // synchronous reset, active low
	input  wire logic raw,     // comparator level
	output logic      level    // filtered level
);
	localparam int CW = $clog2(N + 1);
	logic [CW-1:0] cnt;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt   <= '0;
			level <= 1'b0;
		end else if (raw == level) begin
			cnt <= '0;
		end else if (cnt == CW'(N - 1)) begin
			cnt   <= '0;
			level <= raw;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end
endmodule // vcr_debounce

// ==========================================================
module vcr_regulator import vcr_pkg::*; #(
	parameter int PERIOD = `VCR_PERIOD_CYC,
	parameter int FILTER = `VCR_FILTER_CYC,
	parameter int CRERR  = `VCR_CRERR_CYC
) (
	input  wire logic             aclk,                 // system clock
	input  wire logic             aresetn,              // synchronous reset, active low
	input  wire logic [7:0]       s_axi_awaddr,         // write address
	input  wire logic             s_axi_awvalid,        // write address valid
	output logic                  s_axi_awready,        // write address ready
	input  wire logic [31:0]      s_axi_wdata,          // write data
	input  wire logic [3:0]       s_axi_wstrb,          // write byte enables
	input  wire logic             s_axi_wvalid,         // write data valid
	output logic                  s_axi_wready,         // write data ready
	output logic [1:0]            s_axi_bresp,          // write response
	output logic                  s_axi_bvalid,         // write response valid
	input  wire logic             s_axi_bready,         // write response ready
	input  wire logic [7:0]       s_axi_araddr,         // read address
	input  wire logic             s_axi_arvalid,        // read address valid
	output logic                  s_axi_arready,        // read address ready
	output logic [31:0]           s_axi_rdata,          // read data
	output logic [1:0]            s_axi_rresp,          // read response
	output logic                  s_axi_rvalid,         // read data valid
	input  wire logic             s_axi_rready,         // read data ready
	input  wire logic [3:0][9:0]  adc_current,          // converted load current per channel
	input  wire logic [3:0]       adc_done,             // conversion result strobe
	output logic [3:0]            adc_sample,           // conversion start pulse
	input  wire logic [3:0]       drain_above,          // drain above open load threshold
	input  wire logic [3:0]       overcurrent_raw,      // overcurrent comparator
	input  wire logic [3:0]       overtemp_raw,         // overtemperature comparator
	output logic [3:0]            valve_channel_output  // gate command to power stages
);
	localparam int PW = $clog2(PERIOD + 1);
	localparam int CEW = $clog2(CRERR + 1);

	// ==========================================================
	// registers
	logic [5:0]       ctrl;
	logic [7:0]       integral_gain;
	logic [7:0]       proportional_gain;
	logic [3:0][9:0]  setpoint;
	vcr_flags_t [3:0] flags;
	logic [3:0][10:0] duty_now;
	logic [3:0][9:0]  meas;

	wire [1:0] min_duty_option   = ctrl[`VCR_CTRL_MINDUTY_LSB +: 2];
	wire [1:0] regulation_disable_pair = {ctrl[`VCR_CTRL_PAIR34_BIT], ctrl[`VCR_CTRL_PAIR12_BIT]};
	wire       readback_select   = ctrl[`VCR_CTRL_RDSEL_BIT];
	wire       first_duty_control = ctrl[`VCR_CTRL_FIRST_DUTY_CONTROL_BIT];
	wire [10:0] duty_min = (min_duty_option == 2'h0) ? `VCR_DUTY_MIN10 : `VCR_DUTY_MIN3;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		for (int b = 0; b < 4; b++)
			merge[8*b +: 8] = st[b] ? nw[8*b +: 8] : old[8*b +: 8];
	endfunction

	function automatic logic [2:0] decode(input logic [7:0] a);
		// 0 ctrl, 1 gain, 2 fault clear, 3 status, 4 setpoint, 7 unmapped
		if (a[1:0] != 2'h0)
			decode = 3'h7;
		else if (a == `VCR_OFF_CTRL)
			decode = 3'h0;
		else if (a == `VCR_OFF_GAIN)
			decode = 3'h1;
		else if (a == `VCR_OFF_FCLR)
			decode = 3'h2;
		else if (a == `VCR_OFF_STATUS)
			decode = 3'h3;
		else if (a[7:4] == 4'(`VCR_OFF_SETPOINT >> 4))
			decode = 3'h4;
		else
			decode = 3'h7;
	endfunction

	// ==========================================================
	// write channel: address and data taken in either order
	vcr_wstate_t  wstate;
	logic         aw_full;
	logic         w_full;
	logic [7:0]   aw_addr;
	logic [31:0]  w_data;
	logic [3:0]   w_strb;

	assign s_axi_awready = !aw_full && (wstate == VCR_WR_IDLE);
	assign s_axi_wready  = !w_full && (wstate == VCR_WR_IDLE);
	assign s_axi_bvalid  = (wstate == VCR_WR_RESP);

	wire       do_write = aw_full && w_full && (wstate == VCR_WR_IDLE);
	wire [2:0] wsel     = decode(aw_addr);
	wire [1:0] wch      = aw_addr[3:2];
	wire [3:0] fault_clr = (do_write && wsel == 3'h2 && w_strb[0]) ? w_data[3:0] : 4'h0;
	wire [3:0] sp_wr    = (do_write && wsel == 3'h4 && w_strb[1:0] != 2'h0) ? (4'h1 << wch) : 4'h0;
	wire [31:0] sp_merged = merge({22'h0, setpoint[wch]}, w_data, w_strb);
	wire [31:0] gain_merged = merge({16'h0, proportional_gain, integral_gain}, w_data, w_strb);
	wire [31:0] ctrl_merged = merge({26'h0, ctrl}, w_data, w_strb);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wstate  <= VCR_WR_IDLE;
			aw_full <= 1'b0;
			w_full  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			case (wstate)
				VCR_WR_IDLE: if (do_write) begin
					aw_full     <= 1'b0;
					w_full      <= 1'b0;
					s_axi_bresp <= (wsel == 3'h7 || wsel == 3'h3) ? 2'h2 : 2'h0;
					wstate      <= VCR_WR_RESP;
				end
				VCR_WR_RESP: if (s_axi_bready) begin
					wstate <= VCR_WR_IDLE;
				end
				default: wstate <= VCR_WR_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl              <= `VCR_CTRL_RESET;
			integral_gain     <= `VCR_KI_RESET;
			proportional_gain <= `VCR_KP_RESET;
			setpoint          <= '0;
		end else if (do_write) begin
			if (wsel == 3'h0)
				ctrl <= ctrl_merged[5:0];
			if (wsel == 3'h1) begin
				integral_gain     <= gain_merged[7:0];
				proportional_gain <= gain_merged[15:8];
			end
			if (sp_wr != 4'h0)
				setpoint[wch] <= sp_merged[9:0];
		end
	end

	// ==========================================================
	// read channel: one cycle to answer, status read clears error flags
	wire [2:0] rsel    = decode(s_axi_araddr);
	wire [1:0] rch     = s_axi_araddr[3:2];
	wire       rd_take = s_axi_arvalid && s_axi_arready;
	wire [3:0] crer_rd_clr = (rd_take && rsel == 3'h3) ? 4'hF : 4'h0;
	wire       rch_pwm = regulation_disable_pair[rch[1]];
	wire [10:0] rb_word = !rch_pwm ? (readback_select ? duty_now[rch] : {1'b0, setpoint[rch]}) :
		(readback_select ? {1'b0, meas[rch]} : {3'h0, setpoint[rch][9:2]});
	logic [31:0] status_word;
	always_comb begin
		status_word = 32'h0000_0000;
		for (int c = 0; c < 4; c++) begin
			status_word[c]      = flags[c].regulation_error_flag;
			status_word[4 + c]  = flags[c].open_load;
			status_word[8 + c]  = flags[c].drain_state;
			status_word[12 + c] = flags[c].overcurrent;
			status_word[16 + c] = flags[c].overtemp;
		end
	end
	wire [31:0] rd_mux = (rsel == 3'h0) ? {26'h0, ctrl} :
		(rsel == 3'h1) ? {16'h0, proportional_gain, integral_gain} :
		(rsel == 3'h3) ? status_word :
		(rsel == 3'h4) ? {21'h0, rb_word} : 32'h0000_0000;

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'h0;
		end else if (rd_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= (rsel == 3'h7 || rsel == 3'h2) ? 2'h2 : 2'h0;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// shared period counter
	logic [PW-1:0] cnt;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			cnt <= '0;
		else
			cnt <= (cnt == PW'(PERIOD - 1)) ? '0 : cnt + 1'b1;
	end

	// ==========================================================
	// channels
	for (genvar i = 0; i < 4; i++) begin : g_ch
		localparam logic [PW-1:0] OFFS = PW'(i * PERIOD / 4);
		wire [PW-1:0] phase = (cnt >= OFFS) ? cnt - OFFS : PW'(cnt + PW'(PERIOD) - OFFS);
		wire period_end = (phase == PW'(PERIOD - 1));
		wire pwm_mode = regulation_disable_pair[i / 2];

		logic enabled;
		logic first;
		logic odd;
		logic got;
		logic gate;
		logic signed [19:0] integ;
		logic [10:0] duty_r;
		logic [CEW-1:0] crer_cnt;
		logic oc_lvl;
		logic ot_lvl;
		logic ol_lvl;
		logic ds_lvl;

		// a zero setpoint, or an idle gain outside PWM mode, keeps the stage off
		wire live = enabled && (setpoint[i] != 10'h000) && (pwm_mode || integral_gain != 8'h00);
		wire at_floor = (duty_r <= `VCR_DUTY_MIN3);
		wire forced = !pwm_mode && odd && at_floor && (min_duty_option == 2'h2);
		wire skipped = !pwm_mode && odd && at_floor && (min_duty_option == 2'h3);
		wire [10:0] pwm_duty = (setpoint[i][9:2] == 8'hFF) ? `VCR_DUTY_FULL : {1'b0, setpoint[i][9:2], 2'h0};
		wire [10:0] eff = pwm_mode ? pwm_duty :
			(first && first_duty_control) ? `VCR_DUTY_FULL :
			forced ? `VCR_DUTY_FORCED : skipped ? 11'h000 : duty_r;
		wire [21:0] on_prod = 22'(eff) * 22'(PERIOD);
		wire [PW-1:0] on_len = on_prod[10 +: PW];
		wire on = live && (phase < on_len);

		// sample point slides from half to end of on-time below 10 percent
		wire [PW-1:0] half = on_len >> 1;
		wire [6:0] below = (eff < `VCR_DUTY_MIN10) ? 7'(`VCR_DUTY_MIN10 - eff) : 7'h00;
		wire [25:0] slide = (26'(half) * 26'(below) * 26'(`VCR_SLOPE_MUL)) >> `VCR_SLOPE_SHIFT;
		wire [PW-1:0] late = PW'(26'(half) + slide);
		wire [PW-1:0] samp_pt = (late >= on_len) ? on_len - 1'b1 : late;
		wire take_sample = on && (phase == samp_pt) && !forced && !skipped;

		// PI step, integrator kept in duty units with fractional gain bits
		wire signed [11:0] err = $signed({2'b00, setpoint[i]}) - $signed({2'b00, meas[i]});
		wire signed [19:0] ki_term = $signed({12'h000, integral_gain}) * 20'(err);
		wire signed [19:0] kp_term = $signed({12'h000, proportional_gain}) * 20'(err);
		wire signed [19:0] lo_lim = $signed({3'b000, duty_min, 6'h00});
		wire signed [19:0] hi_lim = $signed({3'b000, `VCR_DUTY_FULL, 6'h00});
		wire signed [19:0] integ_sum = integ + ki_term;
		wire signed [19:0] next_integ = (integ_sum < lo_lim) ? lo_lim : (integ_sum > hi_lim) ? hi_lim : integ_sum;
		wire signed [19:0] pi_sum = next_integ + kp_term;
		wire signed [19:0] pi_clamp = (pi_sum < lo_lim) ? lo_lim : (pi_sum > hi_lim) ? hi_lim : pi_sum;
		wire [10:0] next_duty = pi_clamp[16:6];

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				integ  <= '0;
				duty_r <= `VCR_DUTY_MIN10;
				got    <= 1'b0;
				odd    <= 1'b0;
				first  <= 1'b0;
				meas[i] <= 10'h000;
			end else begin
				if (adc_done[i]) begin
					meas[i] <= adc_current[i];
					got     <= 1'b1;
				end
				if (!live || pwm_mode) begin
					integ  <= lo_lim;
					duty_r <= duty_min;
				end else if (period_end && got) begin
					integ  <= next_integ;
					duty_r <= next_duty;
				end else if (duty_r < duty_min) begin
					duty_r <= duty_min;
				end
				if (period_end) begin
					got <= adc_done[i];
					odd <= !odd;
				end
				if (!live)
					first <= 1'b1;
				else if (period_end)
					first <= 1'b0;
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				gate          <= 1'b0;
				adc_sample[i] <= 1'b0;
				duty_now[i]   <= 11'h000;
			end else begin
				gate          <= on;
				adc_sample[i] <= take_sample;
				duty_now[i]   <= live ? eff : 11'h000;
			end
		end
		assign valve_channel_output[i] = gate;

		// ======================================================
		// supervision
		vcr_debounce #(.N(FILTER)) u_oc (.aclk(aclk), .aresetn(aresetn), .raw(overcurrent_raw[i]), .level(oc_lvl));
		vcr_debounce #(.N(FILTER)) u_ot (.aclk(aclk), .aresetn(aresetn), .raw(overtemp_raw[i]), .level(ot_lvl));
		vcr_debounce #(.N(FILTER)) u_ol (.aclk(aclk), .aresetn(aresetn), .raw(!drain_above[i] && !gate),
			.level(ol_lvl));
		vcr_debounce #(.N(FILTER)) u_ds (.aclk(aclk), .aresetn(aresetn), .raw(drain_above[i]), .level(ds_lvl));

		wire crer_cond = !pwm_mode && live && (err > $signed(`VCR_ERR_THRESH));
		wire crer_hit = crer_cond && (crer_cnt == CEW'(CRERR - 1));

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				crer_cnt <= '0;
				flags[i] <= '0;
				enabled  <= 1'b0;
			end else begin
				crer_cnt <= (!crer_cond || crer_hit || sp_wr[i]) ? '0 : crer_cnt + 1'b1;
				// a detection in the clearing cycle wins
				flags[i].regulation_error_flag <= (flags[i].regulation_error_flag && !crer_rd_clr[i]) ||
					crer_hit;
				flags[i].overcurrent <= (flags[i].overcurrent && !fault_clr[i]) || oc_lvl;
				flags[i].overtemp    <= (flags[i].overtemp && !fault_clr[i]) || ot_lvl;
				flags[i].open_load   <= (flags[i].open_load && !fault_clr[i]) || ol_lvl;
				flags[i].drain_state <= ds_lvl;
				// an overcurrent or overtemperature drops the turn-on command; only a fresh setpoint after clearing restores it
				if (oc_lvl || ot_lvl || flags[i].overcurrent || flags[i].overtemp)
					enabled <= 1'b0;
				else if (sp_wr[i])
					enabled <= 1'b1;
			end
		end
	end
endmodule // vcr_regulator
`default_nettype wire

// ==== test/vcr_regulator_checker.sv ====
/*
 * Port checker of the valve current regulator.
 * Assumes it is bound into vcr_regulator, one clock domain.
 */
`default_nettype none
module vcr_regulator_checker #(
	parameter int FILTER = 20
) (
	input wire logic        aclk,                 // clock
	input wire logic        aresetn,              // reset, active low
	input wire logic        s_axi_bvalid,         // write response valid
	input wire logic        s_axi_bready,         // write response ready
	input wire logic        s_axi_arready,        // read address ready
	input wire logic [31:0] s_axi_rdata,          // read data
	input wire logic        s_axi_rvalid,         // read data valid
	input wire logic        s_axi_rready,         // read data ready
	input wire logic [3:0]  adc_sample,           // conversion start
	input wire logic [3:0]  overcurrent_raw,      // overcurrent comparator
	input wire logic [3:0]  overtemp_raw,         // overtemperature comparator
	input wire logic [3:0]  valve_channel_output  // gate command
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ==========================================================
	// bus handshakes
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped early");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data not held");
	property p_arrdy;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
	endproperty
	a_arrdy: assert property (p_arrdy) else $error("read channel not freed");
	// ==========================================================
	// channel behaviour
	property p_rst;
		$rose(aresetn) |-> valve_channel_output == 4'h0 && !s_axi_bvalid && !s_axi_rvalid;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs active after reset");
	property p_son;
		adc_sample[0] |-> valve_channel_output[0] || $past(valve_channel_output[0]);
	endproperty
	a_son: assert property (p_son) else $error("sample taken while off");
	property p_spulse;
		adc_sample[0] |=> !adc_sample[0];
	endproperty
	a_spulse: assert property (p_spulse) else $error("sample pulse too long");
	// raw fault held past filter, enable drop and gate register must leave the gate off
	logic [7:0] oc_run;
	logic [7:0] ot_run;
	always_ff @(posedge aclk) begin
		oc_run <= overcurrent_raw[3] ? oc_run + 8'(oc_run != 8'hFF) : 8'h00;
		ot_run <= overtemp_raw[3] ? ot_run + 8'(ot_run != 8'hFF) : 8'h00;
	end
	property p_oc;
		oc_run >= FILTER + 2 |-> !valve_channel_output[3];
	endproperty
	a_oc: assert property (p_oc) else $error("overcurrent did not switch off");
	property p_ot;
		ot_run >= FILTER + 2 |-> !valve_channel_output[3];
	endproperty
	a_ot: assert property (p_ot) else $error("overtemperature did not switch off");
endmodule // vcr_regulator_checker

bind vcr_regulator vcr_regulator_checker #(.FILTER(FILTER)) u_checker (
	.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .adc_sample(adc_sample), .overcurrent_raw(overcurrent_raw),
	.overtemp_raw(overtemp_raw), .valve_channel_output(valve_channel_output)
);
`default_nettype wire

// ==== test/vcr_load_model.sv ====
/*
 * Coil and converter model: current ramps while the gate is on.
 * Assumes one clock shared with the regulator.
 */
`default_nettype none
module vcr_load_model import vcr_pkg::*; #(
	parameter logic [9:0] CEIL = 10'h100
) (
	input wire logic       aclk,    // clock
	input wire logic [3:0] gate,    // gate command
	input wire logic [3:0] sample,  // conversion start
	output logic [3:0][9:0] current, // converted current
	output logic [3:0]      done     // result strobe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0][9:0] coil = '0;
	logic [3:0]      pend = '0;
	initial current = '0;
	initial done = '0;
	// result is only valid with done; otherwise the bus shows a garbled value
	always @(posedge aclk) begin
		for (int i = 0; i < 4; i++) begin
			coil[i] <= gate[i] ? ((coil[i] > CEIL - 10'h008) ? CEIL : coil[i] + 10'h008)
				: ((coil[i] < 10'h004) ? 10'h000 : coil[i] - 10'h004);
			current[i] <= pend[i] ? coil[i] : ~coil[i];
		end
		pend <= sample;
		done <= pend;
	end
endmodule // vcr_load_model
`default_nettype wire

// ==== test/vcr_regulator_tb.sv ====
/*
 * Testbench of the valve current regulator over its register bus.
 * Assumes the checker is bound and the load model stands at the gates.
 */
`default_nettype none
`include "vcr_consts.svh"
module vcr_regulator_tb import vcr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PER = 64;
	logic            aclk, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
	logic            awr, wrd, bv, arr, rv;
	logic [7:0]      awa = '0, ara = '0;
	logic [31:0]     wd = '0, rdata;
	logic [1:0]      br, rr, wresp;
	logic [3:0]      drn = 4'b1011, ocr = '0, otr = '0, smp, gate, done;
	logic [3:0][9:0] cur;
	int              fails = 0, comparisons = 0, cyc = 0;
	time             rise [4];
	vcr_regulator #(.PERIOD(PER), .FILTER(3), .CRERR(16)) uut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
		.adc_current(cur), .adc_done(done), .adc_sample(smp), .drain_above(drn),
		.overcurrent_raw(ocr), .overtemp_raw(otr), .valve_channel_output(gate)
	);
	vcr_load_model lm (.aclk(aclk), .gate(gate), .sample(smp), .current(cur), .done(done));
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	for (genvar g = 0; g < 4; g++) begin : g_rise
		always @(posedge gate[g]) rise[g] = $time;
	end
	// ==========================================================
	// bus master tasks
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		do begin
			@(posedge aclk);
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
		end while (bv !== 1'b1);
		wresp = br;
		bre <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		do begin
			@(posedge aclk);
			if (arr) arv <= 1'b0;
		end while (rv !== 1'b1);
		d = rdata;
		r = rr;
		rre <= 1'b0;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(n, e, d & m);
	endtask
	task automatic ontime(input int ch, output int k);
		k = 0;
		repeat (2 * PER) begin
			@(posedge aclk);
			if (gate[ch] === 1'b1) k++;
		end
	endtask
	task automatic results();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// a hang ends the run well past the expected 3000 cycles
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fails++;
			results();
		end
	end
	// ==========================================================
	// test sequence
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		int          k;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rchk("ctrl", 8'h00, 32'h0, 32'hFFFF_FFFF);
		rchk("gain", 8'h04, 32'h8, 32'hFFFF);
		rd(8'h40, d, r);
		chk("unmapped", 2'b10, r);
		wr(8'h0C, 32'hFFFF_FFFF);
		chk("status write", 2'b10, wresp);
		rchk("drain", 8'h0C, 32'h0B00, 32'h0F00);
		rchk("open load", 8'h0C, 32'h0040, 32'h00F0);
		$display("test reset done");
		wr(8'h04, 32'h0);
		wr(8'h10, 32'h3FF);
		ontime(0, k);
		chk("idle", 0, k);
		wr(8'h04, 32'h0810);
		chk("write resp", 2'b00, wresp);
		ontime(0, k);
		chk("running", 1, k > 0);
		rchk("setpoint", 8'h10, 32'h3FF, 32'h3FF);
		wr(8'h00, 32'h10);
		rd(8'h10, d, r);
		chk("duty clamp", 1, d >= `VCR_DUTY_MIN10 && d <= `VCR_DUTY_FULL);
		repeat (6 * PER) @(posedge aclk);
		rchk("reg error", 8'h0C, 32'h1, 32'h1);
		ontime(0, k);
		chk("still on", 1, k > 0);
		wr(8'h10, 32'h0);
		ontime(0, k);
		chk("zero off", 0, k);
		rd(8'h0C, d, r);
		rchk("error clear", 8'h0C, 32'h0, 32'h1);
		wr(8'h00, 32'h31);
		wr(8'h10, 32'h1);
		@(posedge aclk);
		chk("first duty", 1, gate[0]);
		repeat (2 * PER) @(posedge aclk);
		rchk("min duty", 8'h10, `VCR_DUTY_MIN3, 32'h7FF);
		$display("test regulation done");
		wr(8'h00, 32'h0C);
		for (int c = 0; c < 2; c++) begin
			wr(8'h10, c ? 32'h3FC : 32'h0);
			repeat (PER) @(posedge aclk);
			ontime(0, k);
			chk("pwm on", c ? 2 * PER : 0, k);
			rchk("pwm duty", 8'h10, c ? 32'hFF : 32'h0, 32'hFF);
		end
		wr(8'h00, 32'h1C);
		rchk("pwm adc", 8'h10, 32'h100, 32'h3FF);
		for (int i = 0; i < 4; i++) wr(8'h10 + 8'(4 * i), 32'h200);
		repeat (4 * PER) @(posedge aclk);
		for (int i = 1; i < 4; i++) chk("phase", i * PER * 25, (rise[i] + PER * 100 - rise[0]) % (PER * 100));
		$display("test pwm done");
		for (int f = 0; f < 2; f++) begin
			@(posedge aclk);
			ocr[3] <= (f == 0);
			otr[3] <= (f == 1);
			repeat (10) @(posedge aclk);
			ocr <= '0;
			otr <= '0;
			ontime(3, k);
			chk("fault off", 0, k);
			ontime(2, k);
			chk("other on", 1, k > 0);
			rchk("fault flag", 8'h0C, 32'h1 << (15 + 4 * f), 32'h1 << (15 + 4 * f));
			wr(8'h08, 32'h8);
			rchk("fault clear", 8'h0C, 32'h0, 32'h1 << (15 + 4 * f));
			ontime(3, k);
			chk("stays off", 0, k);
			wr(8'h1C, 32'h200);
			ontime(3, k);
			chk("restart", 1, k > 0);
		end
		$display("test faults done");
		results();
	end
endmodule // vcr_regulator_tb
`default_nettype wire
